/* rtl/scan_seq.sv */
// Simultaneous scan sequencer with channel list and Wishbone slave
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Whole digital port is one list entry
// - Wide value: low word, then high word
// - Counter words map to variant channel numbers
// - Decoder words map to consecutive channel numbers
// - All entries captured on same sample tick
// - Internal rate programmable within variant limits
// - External clock ticks on its falling edge
// - Single value: one channel, returned at once
// - Single value ends alone, cannot stop
// - Scan configured before acquisition begins
// - Orderly stop finishes buffer, ignores triggers
// - Abrupt stop returns partial buffer at once
// - Low channels analog, order irrelevant
// - Each tick in ST_RUN captures all sources, listed emitted
module scan_seq #(
   parameter longint MAX_PERIOD = scan_pkg::MAX_PERIOD_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [63:0] adc_data_i,
   input wire logic [15:0] din_i,
   input wire logic [63:0] ctr_i,
   input wire logic [95:0] dec_i,
   input wire logic ext_clk_i,
   input wire logic ext_trig_i,
   input wire logic thresh_hit_i,
   output logic conv_start_o,
   output logic [15:0] word_o,
   output logic word_valid_o,
   input wire logic word_ready_i,
   output logic buf_done_o,
   output logic buf_partial_o
);
   import scan_pkg::*;

   // ---------------------------------------------------------------
   // Word selection
   // ---------------------------------------------------------------
   // Map a list channel onto the snapshot word index; the two-input
   // variant numbers everything past its analog pair two lower
   function automatic logic [3:0] canon(input logic [3:0] ch,
                                        input logic two);
      canon = ch;
      if (two && ch >= ANALOG_TWO) begin
         canon = ch + TWO_SHIFT;
      end
   endfunction

   // Byte-lane merge for Wishbone writes
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] sel);
      for (int b = 0; b < 4; b++) begin
         merge[b*8+:8] = sel[b] ? nw[b*8+:8] : old[b*8+:8];
      end
   endfunction

   // ---------------------------------------------------------------
   // Sources and snapshot
   // ---------------------------------------------------------------
   // Word k of src is channel k of the four-input numbering:
   // analog 0-3, port 4, counter words 5-8, decoder words 9-14
   logic [239:0] src;
   logic [239:0] snap_flat; // Flat view of the latched copy, read by the assertions
   logic take; // Capture strobe for the snapshot
   logic [15:0] snap [NUM_WORDS];
   assign src = {dec_i, ctr_i, din_i, adc_data_i};

   generate
      for (genvar k = 0; k < NUM_WORDS; k++) begin : g_snap
         logic [15:0] next_word_k;
         // Every source is latched on the same tick, so low and
         // high halves of a wide value always belong together
         always_comb begin
            next_word_k = take ? src[k*16+:16] : snap[k];
         end
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               snap[k] <= 16'h0000;
            end else begin
               snap[k] <= next_word_k;
            end
         end
         assign snap_flat[k*16+:16] = snap[k];
      end
   endgenerate

   // ---------------------------------------------------------------
   // Configuration state
   // ---------------------------------------------------------------
   logic [31:0] rate_div, next_rate_div; // Period in clock cycles
   logic [3:0] list_len, next_list_len; // Entries in use
   logic [15:0] buf_len, next_buf_len; // Words per buffer
   logic [3:0] sch, next_sch; // Single-value channel
   logic [15:0] sdata, next_sdata; // Single-value result
   logic sready, next_sready; // Single-value result fresh
   logic cfg_ext, next_cfg_ext; // External clock selected
   trig_t cfg_trig, next_cfg_trig; // Initial trigger source
   logic cfg_two, next_cfg_two; // Two-input variant numbering
   logic [3:0] list [NUM_WORDS]; // Channel list entries
   logic [3:0] next_list [NUM_WORDS];
   state_t state, next_state;
   logic wr, rd; // Bus request taken this cycle
   logic go, ord_req, abr_req, single_req; // Control pulses
   logic [31:0] ctrl_w;
   logic [31:0] buf_w; // Byte-merged buffer length write

   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
   assign buf_w = merge({16'h0000, buf_len}, wb_dat_i, wb_sel_i);
   assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
   assign ctrl_w = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
   assign go = wr && wb_adr_i == CTRL_OFS && ctrl_w[CTRL_START_BIT];
   assign ord_req = wr && wb_adr_i == CTRL_OFS
                    && ctrl_w[CTRL_ORDERLY_BIT];
   assign abr_req = wr && wb_adr_i == CTRL_OFS
                    && ctrl_w[CTRL_ABRUPT_BIT];
   assign single_req = wr && wb_adr_i == CTRL_OFS
                       && ctrl_w[CTRL_SINGLE_BIT];

   // Setup registers accept writes only while idle, so a running
   // scan cannot see its list, clock or trigger change underneath it
   always_comb begin
      next_rate_div = rate_div;
      next_list_len = list_len;
      next_buf_len = buf_len;
      next_sch = sch;
      next_sdata = sdata;
      next_sready = sready && !rd;
      next_cfg_ext = cfg_ext;
      next_cfg_trig = cfg_trig;
      next_cfg_two = cfg_two;
      next_list = list;
      if (wr && state == ST_IDLE) begin
         unique case (wb_adr_i)
            CTRL_OFS: begin
               if (wb_sel_i[0]) begin
                  next_cfg_ext = wb_dat_i[CTRL_EXTCLK_BIT];
                  next_cfg_trig = trig_t'(wb_dat_i[CTRL_TRIG_LSB+:2]);
                  next_cfg_two = wb_dat_i[CTRL_TWO_BIT];
               end
            end
            RATE_OFS: next_rate_div = merge(rate_div, wb_dat_i,
                                            wb_sel_i);
            LEN_OFS: begin
               if (wb_sel_i[0]) begin
                  next_list_len = wb_dat_i[3:0];
               end
            end
            BUFLEN_OFS: next_buf_len = buf_w[15:0];
            SCH_OFS: begin
               if (wb_sel_i[0]) begin
                  next_sch = wb_dat_i[3:0];
               end
            end
            default: begin
               if (wb_adr_i >= LIST_OFS && wb_sel_i[0]
                   && wb_adr_i[5:2] < 4'(NUM_WORDS)) begin
                  next_list[wb_adr_i[5:2]] = wb_dat_i[3:0];
               end
            end
         endcase
      end
      // Single value reads the live source with no clock, trigger
      // or list, and has nothing to stop: it is done in one cycle
      if (single_req && state == ST_IDLE) begin
         next_sdata = src[canon(sch, cfg_two)*16+:16];
         next_sready = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rate_div <= RATE_RESET;
         list_len <= LEN_RESET;
         buf_len <= BUFLEN_RESET;
         sch <= 4'h0;
         sdata <= 16'h0000;
         sready <= 1'b0;
         cfg_ext <= 1'b0;
         cfg_trig <= TRIG_SW;
         cfg_two <= 1'b0;
         list <= '{default: 4'h0};
      end else begin
         rate_div <= next_rate_div;
         list_len <= next_list_len;
         buf_len <= next_buf_len;
         sch <= next_sch;
         sdata <= next_sdata;
         sready <= next_sready;
         cfg_ext <= next_cfg_ext;
         cfg_trig <= next_cfg_trig;
         cfg_two <= next_cfg_two;
         list <= next_list;
      end
   end

   // ---------------------------------------------------------------
   // Pacing
   // ---------------------------------------------------------------
   logic [31:0] period; // Clamped to the variant's rate limits
   logic rate_tick, tick;
   logic [2:0] rise, fall; // ext clock, ext trigger, threshold
   logic [3:0] len_eff; // List length clamped to the variant max

   always_comb begin
      period = rate_div;
      if (cfg_two && period < 32'(MIN_PERIOD_TWO)) begin
         period = 32'(MIN_PERIOD_TWO);
      end else if (!cfg_two && period < 32'(MIN_PERIOD_FOUR)) begin
         period = 32'(MIN_PERIOD_FOUR);
      end else if (period > 32'(MAX_PERIOD)) begin
         period = 32'(MAX_PERIOD);
      end
      // A longer list than the variant holds is cut, never wrapped
      len_eff = list_len;
      if (cfg_two && list_len > LIST_MAX_TWO) begin
         len_eff = LIST_MAX_TWO;
      end
   end

   rate_gen u_rate (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .en_i(!cfg_ext && state != ST_IDLE && state != ST_ARMED),
      .period_i(period),
      .tick_o(rate_tick)
   );

   edge_det #(.W(3)) u_edges (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_i({thresh_hit_i, ext_trig_i, ext_clk_i}),
      .rise_o(rise),
      .fall_o(fall)
   );

   // External clock paces on its falling edge only
   assign tick = cfg_ext ? fall[0] : rate_tick;

   // ---------------------------------------------------------------
   // Sequencer: trigger, capture, ordered emission, stops
   // ---------------------------------------------------------------
   logic [3:0] idx, next_idx; // Next list entry to send
   logic [15:0] word_cnt, next_word_cnt; // Words in current buffer
   logic ord_pend, next_ord_pend; // Orderly stop requested
   logic trig_hit;
   logic [15:0] next_word;
   logic next_valid, next_conv, next_done, next_partial;

   always_comb begin
      unique case (cfg_trig)
         TRIG_SW: trig_hit = 1'b1;
         TRIG_POS: trig_hit = rise[1];
         TRIG_NEG: trig_hit = fall[1];
         TRIG_THRESH: trig_hit = rise[2];
      endcase
   end

   assign take = tick && state == ST_RUN;

   always_comb begin
      next_state = state;
      next_idx = idx;
      next_word_cnt = word_cnt;
      next_ord_pend = ord_pend || ord_req;
      next_word = word_o;
      next_valid = word_valid_o;
      next_conv = take;
      next_done = 1'b0;
      next_partial = 1'b0;
      unique case (state)
         // Triggers are ignored here, also after any stop
         ST_IDLE: begin
            next_ord_pend = 1'b0;
            if (go) begin
               next_state = ST_ARMED;
               next_word_cnt = 16'h0000;
            end
         end
         ST_ARMED: begin
            if (trig_hit) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (take) begin
               next_state = ST_EMIT;
               next_idx = 4'h0;
            end
         end
         ST_EMIT: begin
            // Ticks arriving mid-emission are dropped, not queued
            if (!word_valid_o || word_ready_i) begin
               if (word_valid_o) begin
                  next_word_cnt = word_cnt + 16'h0001;
               end
               if (idx < len_eff) begin
                  next_word = snap[canon(list[idx], cfg_two)];
                  next_valid = 1'b1;
                  next_idx = idx + 4'h1;
               end else begin
                  next_valid = 1'b0;
                  next_state = ST_RUN;
               end
            end
         end
      endcase
      // Full buffer goes back; an orderly stop ends here
      if (state != ST_IDLE && next_word_cnt >= buf_len
          && buf_len != 16'h0000) begin
         next_done = 1'b1;
         next_word_cnt = 16'h0000;
         // Orderly stop ends with this buffer; a word already loaded
         // belongs to the next buffer and is dropped
         if (next_ord_pend) begin
            next_state = ST_IDLE;
            next_valid = 1'b0;
         end
      end else if (next_ord_pend && state == ST_ARMED) begin
         next_state = ST_IDLE;
      end
      // Abrupt stop wins over everything and returns what exists
      if (abr_req && state != ST_IDLE) begin
         next_state = ST_IDLE;
         next_valid = 1'b0;
         next_conv = 1'b0;
         next_done = 1'b1;
         next_partial = 1'b1;
         next_word_cnt = 16'h0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
         idx <= 4'h0;
         word_cnt <= 16'h0000;
         ord_pend <= 1'b0;
         word_o <= 16'h0000;
         word_valid_o <= 1'b0;
         conv_start_o <= 1'b0;
         buf_done_o <= 1'b0;
         buf_partial_o <= 1'b0;
      end else begin
         state <= next_state;
         idx <= next_idx;
         word_cnt <= next_word_cnt;
         ord_pend <= next_ord_pend;
         word_o <= next_word;
         word_valid_o <= next_valid;
         conv_start_o <= next_conv;
         buf_done_o <= next_done;
         buf_partial_o <= next_partial;
      end
   end

   // ---------------------------------------------------------------
   // Wishbone read data and acknowledge
   // ---------------------------------------------------------------
   logic [31:0] next_dat;

   // Unmapped addresses below 0x80 read zero and still acknowledge; from 0x80 up the list decode repeats
   always_comb begin
      next_dat = 32'h0000_0000;
      unique case (wb_adr_i)
         CTRL_OFS: next_dat = {25'h0, cfg_two, cfg_trig, 2'h0, cfg_ext,
                               1'b0};
         STAT_OFS: next_dat = {word_cnt, 10'h0, sready, ord_pend,
                               state};
         RATE_OFS: next_dat = rate_div;
         LEN_OFS: next_dat = {28'h0, list_len};
         BUFLEN_OFS: next_dat = {16'h0, buf_len};
         SCH_OFS: next_dat = {28'h0, sch};
         SDATA_OFS: next_dat = {16'h0, sdata};
         default: begin
            if (wb_adr_i >= LIST_OFS && wb_adr_i[5:2] < 4'(NUM_WORDS)) begin
               next_dat = {28'h0, list[wb_adr_i[5:2]]};
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= rd ? next_dat : 32'h0000_0000;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   logic [31:0] gap; // Cycles since the last internal tick
   always_ff @(posedge clk_i) begin
      if (rst_i || rate_tick) begin
         gap <= 32'h0000_0001;
      end else if (gap != 32'hFFFF_FFFF) begin
         gap <= gap + 32'h0000_0001;
      end
   end

   sequence abrupt_in_run_s;
      abr_req && state != ST_IDLE;
   endsequence
   sequence partial_return_s;
      buf_done_o && buf_partial_o && !word_valid_o;
   endsequence

   tick_capture_a: assert property (@(posedge clk_i) disable iff (rst_i)
      take |=> conv_start_o && snap_flat == $past(src))
      else $error("tick did not capture all sources");
   hold_word_a: assert property (@(posedge clk_i) disable iff (rst_i)
      word_valid_o && !word_ready_i && !abr_req |=> $stable(word_o))
      else $error("stream word changed while stalled");
   abrupt_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
      abrupt_in_run_s |=> partial_return_s ##0 state == ST_IDLE)
      else $error("abrupt stop did not return partial buffer");
   idle_deaf_a: assert property (@(posedge clk_i) disable iff (rst_i)
      state == ST_IDLE && !go |=> state == ST_IDLE)
      else $error("sequencer left idle without a start");
   rate_limit_a: assert property (@(posedge clk_i) disable iff (rst_i)
      rate_tick && $past(rate_tick, 1) == 1'b0 && !cfg_two
      && gap > 32'h1 |-> gap >= 32'(MIN_PERIOD_FOUR))
      else $error("internal rate above the limit");
   ext_fall_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_ext && state == ST_RUN && fall[0] && !abr_req |=> conv_start_o)
      else $error("falling external clock did not start a conversion");
   single_now_a: assert property (@(posedge clk_i) disable iff (rst_i)
      single_req && state == ST_IDLE |=> sready
      && sdata == $past(src[canon(sch, cfg_two)*16+:16]))
      else $error("single value not returned at once");
   snap_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !take |=> $stable(snap_flat))
      else $error("snapshot changed outside a tick");
   orderly_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ord_pend && buf_done_o |-> state == ST_IDLE && !word_valid_o)
      else $error("orderly stop did not end after a full buffer");
endmodule
`default_nettype wire

/* rtl/scan_pkg.sv */
// Shared constants and types for the simultaneous scan sequencer
package scan_pkg;
   // ---------------------------------------------------------------
   // Clock and pacing
   // ---------------------------------------------------------------
   localparam longint CLK_HZ = 25000000;
   localparam real MIN_RATE_SPS = 0.01118;
   localparam longint MAX_RATE_FOUR_KSPS = 1250;
   localparam longint MAX_RATE_TWO_KSPS = 2000;
   // Fastest rate gives the least period, rounded up
   localparam int MIN_PERIOD_FOUR = int'((CLK_HZ
      + MAX_RATE_FOUR_KSPS * 1000 - 1) / (MAX_RATE_FOUR_KSPS * 1000));
   localparam int MIN_PERIOD_TWO = int'((CLK_HZ
      + MAX_RATE_TWO_KSPS * 1000 - 1) / (MAX_RATE_TWO_KSPS * 1000));
   // Slowest rate gives the longest period, rounded down
   localparam longint MAX_PERIOD_CYC =
      longint'($floor(real'(CLK_HZ) / MIN_RATE_SPS));
   localparam logic [31:0] RATE_RESET = 32'h0000_0014;
   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] RATE_OFS = 8'h08;
   localparam logic [7:0] LEN_OFS = 8'h0C;
   localparam logic [7:0] BUFLEN_OFS = 8'h10;
   localparam logic [7:0] SCH_OFS = 8'h14;
   localparam logic [7:0] SDATA_OFS = 8'h18;
   localparam logic [7:0] LIST_OFS = 8'h40;
   // Control register fields
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_EXTCLK_BIT = 1;
   localparam int CTRL_ORDERLY_BIT = 2;
   localparam int CTRL_ABRUPT_BIT = 3;
   localparam int CTRL_TRIG_LSB = 4;
   localparam int CTRL_TWO_BIT = 6;
   localparam int CTRL_SINGLE_BIT = 7;
   // Reset values
   localparam logic [3:0] LEN_RESET = 4'h1;
   localparam logic [15:0] BUFLEN_RESET = 16'h0100;
   // ---------------------------------------------------------------
   // Channel list geometry
   // ---------------------------------------------------------------
   localparam int NUM_WORDS = 15;
   localparam logic [3:0] LIST_MAX_FOUR = 4'hF;
   localparam logic [3:0] LIST_MAX_TWO = 4'hD;
   localparam logic [3:0] ANALOG_TWO = 4'h2;
   localparam logic [3:0] TWO_SHIFT = 4'h2;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      TRIG_SW = 2'h0,
      TRIG_POS = 2'h1,
      TRIG_NEG = 2'h2,
      TRIG_THRESH = 2'h3
   } trig_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_ARMED = 4'h2,
      ST_RUN = 4'h4,
      ST_EMIT = 4'h8
   } state_t;
endpackage

/* rtl/rate_gen.sv */
// Internal sample-rate divider producing a one-cycle tick enable
`timescale 1ns/10ps
`default_nettype none
module rate_gen (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   input wire logic [31:0] period_i,
   output logic tick_o
);
   logic [31:0] cnt; // Cycles since the last tick
   logic [31:0] next_cnt;
   logic next_tick;

   // ---------------------------------------------------------------
   // Divider: tick once every period_i cycles while enabled
   // ---------------------------------------------------------------
   always_comb begin
      next_cnt = cnt + 32'h0000_0001;
      next_tick = 1'b0;
      if (!en_i) begin
         // Restart so the first tick is a full period after enable
         next_cnt = 32'h0000_0000;
      end else if (cnt >= period_i - 32'h0000_0001) begin
         next_cnt = 32'h0000_0000;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= 32'h0000_0000;
         tick_o <= 1'b0;
      end else begin
         cnt <= next_cnt;
         tick_o <= next_tick;
      end
   end
endmodule
`default_nettype wire

/* rtl/edge_det.sv */
// Edge detector for a group of inputs synchronous to the clock
`timescale 1ns/10ps
`default_nettype none
module edge_det #(
   parameter int W = 3
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] in_i,
   output logic [W-1:0] rise_o,
   output logic [W-1:0] fall_o
);
   logic [W-1:0] prev; // Level seen one cycle earlier

   // ---------------------------------------------------------------
   // Edges compare the present level with the stored one
   // ---------------------------------------------------------------
   always_comb begin
      rise_o = in_i & ~prev;
      fall_o = ~in_i & prev;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev <= '0;
      end else begin
         prev <= in_i;
      end
   end
endmodule
`default_nettype wire

/* verif/stream_sink.sv */
// Host-side stream sink that stalls the sequencer now and then
`timescale 1ns/10ps
`default_nettype none
module stream_sink (
   input wire logic clk_i,
   input wire logic rst_i,
   output logic ready_o
);
   logic [1:0] cnt; // Free-running phase of the stall pattern
   // Counter advances every cycle once out of reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= 2'h0;
      end else begin
         cnt <= cnt + 2'h1;
      end
   end
   // One stall in four cycles exercises the held-word path
   assign ready_o = (cnt != 2'h3);
endmodule
`default_nettype wire

/* verif/simultaneous_scan_channel_list_tb.sv */
// Self-checking bench for the scan sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fail_count++; \
   $display("[FAIL] %s exp %h got %h", n, e, s); end end
module simultaneous_scan_channel_list_tb;
   import scan_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, rdy, ab = 0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic ack, vld, done, part, conv, xclk = 0, xtrig = 0;
   logic [15:0] word, din = 16'h0, seed = 16'h0062;
   logic [63:0] adc = 64'h0, ctr = 64'h0;
   logic [95:0] dec = 96'h0;
   logic [15:0] got[$];
   int fail_count = 0, compares = 0, cyc_n = 0, n, cv = 0, dn = 0, c0, d0;
   int lst[6] = '{13, 14, 4, 0, 5, 6};
   always #20 clk_i = ~clk_i;
   // Short longest period keeps the run brief
   scan_seq #(.MAX_PERIOD(1000)) DUT (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .adc_data_i(adc), .din_i(din), .ctr_i(ctr), .dec_i(dec),
      .ext_clk_i(xclk), .ext_trig_i(xtrig), .thresh_hit_i(1'b0),
      .conv_start_o(conv), .word_o(word), .word_valid_o(vld),
      .word_ready_i(rdy), .buf_done_o(done), .buf_partial_o(part));
   stream_sink SNK (.clk_i(clk_i), .rst_i(rst_i), .ready_o(rdy));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Word a four-input channel number should yield
   function automatic logic [15:0] exp_w(input int c);
      logic [239:0] all;
      all = {dec, ctr, din, adc};
      return all[c * 16 +: 16];
   endfunction
   // Fresh random values on every source
   task automatic rnd;
      logic [239:0] v;
      for (int i = 0; i < 15; i++) begin
         seed = lfsr(seed);
         v = {seed, v[239:16]};
      end
      {dec, ctr, din, adc} <= v;
   endtask
   // Classic single Wishbone cycle, held until ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task test_done;
      if (fail_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Stream capture, abrupt-stop watch and hang guard
   always @(posedge clk_i) begin
      if (vld === 1'b1 && rdy === 1'b1) got.push_back(word);
      if (done === 1'b1 && part === 1'b1) ab <= 1'b1;
      if (done === 1'b1 && part === 1'b0) dn <= dn + 1;
      if (conv === 1'b1) cv <= cv + 1;
      cyc_n <= cyc_n + 1;
      if (cyc_n == 20000) begin
         fail_count++;
         test_done();
      end
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, RATE_OFS, '0);
      `CHK("rate", 32'h14, q)
      wb(1'b0, BUFLEN_OFS, '0);
      `CHK("buflen", 32'h100, q)
      wb(1'b0, 8'h30, '0);
      `CHK("hole", 32'h0, q)
      // Single reads on every channel in both numberings
      for (int k = 0; k < 28; k++) begin
         n = (k > 14) ? k - 15 : k;
         rnd();
         wb(1'b1, SCH_OFS, n);
         wb(1'b1, CTRL_OFS, (k > 14) ? 32'hC0 : 32'h80);
         wb(1'b0, SDATA_OFS, '0);
         if (k > 14 && n >= 2) n = n + 2;
         `CHK("single", exp_w(n), q[15:0])
      end
      // Mixed list scan, sources held so both ticks match
      rnd();
      // Too fast a rate must be held at the variant's limit
      wb(1'b1, RATE_OFS, 32'h5);
      for (int i = 0; i < 6; i++) wb(1'b1, LIST_OFS + 8'(i * 4), lst[i]);
      wb(1'b1, LEN_OFS, 32'h6);
      wb(1'b1, BUFLEN_OFS, '0);
      got.delete();
      wb(1'b1, CTRL_OFS, 32'h1);
      while (got.size() < 12) @(posedge clk_i);
      for (int i = 0; i < 12; i++) `CHK("word", exp_w(lst[i % 6]), got[i])
      wb(1'b1, CTRL_OFS, 32'h8);
      repeat (2) @(posedge clk_i);
      n = got.size();
      `CHK("abrupt", 1'b1, ab)
      repeat (100) @(posedge clk_i);
      `CHK("halted", n, got.size())
      wb(1'b0, STAT_OFS, '0);
      `CHK("idle", 4'h1, q[3:0])
      // Falling trigger, external ticks, orderly stop ending the second buffer
      wb(1'b1, BUFLEN_OFS, 32'h6);
      c0 = cv;
      d0 = dn;
      n = got.size();
      wb(1'b1, CTRL_OFS, 32'h23);
      xtrig <= 1'b1;
      @(posedge clk_i) xtrig <= 1'b0;
      for (int t = 0; t < 3; t++) begin
         if (t == 1) wb(1'b1, CTRL_OFS, 32'h4);
         rnd();
         @(posedge clk_i) xclk <= 1'b1;
         repeat (4) @(posedge clk_i);
         `CHK("rise", c0 + (t < 2 ? t : 2), cv)
         xclk <= 1'b0;
         repeat (30) @(posedge clk_i);
         `CHK("ticks", c0 + (t < 2 ? t + 1 : 2), cv)
         for (int i = 0; i < 6 && t < 2; i++)
            `CHK("xword", exp_w(lst[i]), got[n + t * 6 + i])
      end
      `CHK("bufs", d0 + 2, dn)
      `CHK("drain", n + 12, got.size())
      wb(1'b0, STAT_OFS, '0);
      `CHK("stopped", 4'h1, q[3:0])
      test_done();
   end
endmodule
`default_nettype wire
